// ---- hw/sgc_ctrl_regs.sv ----
// port-5 host interface configuration, null vlan id replacement and
// broadcast storm metering, reached over an apb slave
// assumes apb3 signalling and one pulse per 64-byte broadcast block per port
`timescale 1ns/1ps

// Function
// - host duplex bit set means half duplex, clear means full duplex.
// - duplex bit resets to its strap level; low gives full duplex.
// - host flow control bit set enables full-duplex pause, clear disables.
// - flow control bit resets to its strap level; low disables it.
// - host speed bit set means 10 Mbps, clear means 100 Mbps.
// - speed bit resets to its strap level; low gives 100 Mbps.
// - replacement bit set swaps a null vlan identifier for port default.
// - storm threshold is 11 bits, upper three in one register.
// - storm period is 50 ms at 100 Mbps, 500 ms at 10 Mbps.
// - threshold resets to 0x4A, upper bits zero.
module sgc_ctrl_regs
    import sgc_pkg::*;
#(
    parameter int unsigned FAST_PERIOD_CYC = STORM_FAST_CYC,
    parameter int unsigned SLOW_PERIOD_CYC = STORM_SLOW_CYC
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [7:0]           paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire logic                 duplex_strap_pin_i,
    input  wire logic                 pause_strap_pin_i,
    input  wire logic                 speed_strap_pin_i,
    input  wire logic [NUM_PORTS-1:0] port_slow_i,
    input  wire logic [NUM_PORTS-1:0] bcast_block_i,
    output logic      [NUM_PORTS-1:0] drop_bcast_o,
    input  wire logic [VID_W-1:0]     vlan_id_i,
    input  wire logic [VID_W-1:0]     port_vid_i,
    output logic      [VID_W-1:0]     vlan_id_o,
    output logic                      host_half_duplex_o,
    output logic                      host_flow_ctrl_o,
    output logic                      host_speed_10_o,
    output logic                      null_vid_replace_o,
    output logic                      back_pressure_o,
    output logic                      rmii_edge_o,
    output logic                      power_save_o,
    output logic      [THR_W-1:0]     storm_threshold_o
);

    // ==================================================================
    // state
    typedef struct packed {
        logic [7:0]                       host_ctrl;
        logic [7:0]                       storm_lo;
        logic [7:0]                       ctrl9;
        logic [31:0]                      rdata;
        logic                             ready;
        logic                             err;
        logic [NUM_PORTS-1:0][THR_W-1:0] cnt;
        logic [NUM_PORTS-1:0]             drop;
        logic [VID_W-1:0]                 vid_out;
    } sgc_regs_t;

    sgc_regs_t  r;
    sgc_regs_t  next_r;
    logic       tick_fast;
    logic       tick_slow;
    logic [THR_W-1:0] thr;

    // ==================================================================
    // storm period timers
    sgc_period_tick #(
        .PERIOD_CYC (FAST_PERIOD_CYC)
    ) u_fast_tick (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .tick_o (tick_fast)
    );

    sgc_period_tick #(
        .PERIOD_CYC (SLOW_PERIOD_CYC)
    ) u_slow_tick (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .tick_o (tick_slow)
    );

    assign thr = {r.host_ctrl[2:0], r.storm_lo};

    // ==================================================================
    // next state
    always_comb begin
        logic       hit;
        logic [7:0] rd;
        logic       tick_sel;
        hit      = 1'b1;
        rd       = 8'h00;
        tick_sel = 1'b0;
        next_r   = r;

        // read decode
        case (paddr_i[7:2])
            IDX_HOST_CTRL: rd = r.host_ctrl;
            IDX_STORM_LO:  rd = r.storm_lo;
            IDX_TEST_A:    rd = TEST_A_VAL;
            IDX_TEST_B:    rd = TEST_B_VAL;
            IDX_TEST_C:    rd = TEST_C_VAL;
            IDX_CTRL9:     rd = r.ctrl9;
            default:       hit = 1'b0;
        endcase
        if (paddr_i[1:0] != 2'b00) begin
            hit = 1'b0;
        end

        // apb answer one cycle after setup
        next_r.ready = 1'b0;
        next_r.err   = 1'b0;
        next_r.rdata = '0;
        if (psel_i && !penable_i) begin
            next_r.ready = 1'b1;
            next_r.err   = !hit;
            if (hit && !pwrite_i) begin
                next_r.rdata = {24'h00_0000, rd};
            end
        end

        // write at completing access edge; test registers ignore writes
        if (psel_i && penable_i && r.ready && pwrite_i && hit) begin
            case (paddr_i[7:2])
                IDX_HOST_CTRL: next_r.host_ctrl = pwdata_i[7:0];
                IDX_STORM_LO:  next_r.storm_lo  = pwdata_i[7:0];
                IDX_CTRL9: begin
                    next_r.ctrl9 = (r.ctrl9 & ~CTRL9_RW_MASK) | (pwdata_i[7:0] & CTRL9_RW_MASK);
                end
                default: next_r.ctrl9 = r.ctrl9;
            endcase
        end

        // null vlan identifier replacement
        if (r.host_ctrl[NULL_VID_BIT] && vlan_id_i == '0) begin
            next_r.vid_out = port_vid_i;
        end else begin
            next_r.vid_out = vlan_id_i;
        end

        // per-port broadcast block metering
        for (int p = 0; p < NUM_PORTS; p++) begin
            tick_sel = port_slow_i[p] ? tick_slow : tick_fast;
            if (tick_sel) begin
                next_r.cnt[p] = '0;
            end else if (bcast_block_i[p] && r.cnt[p] < thr) begin
                next_r.cnt[p] = r.cnt[p] + 1'b1;
            end
            next_r.drop[p] = (next_r.cnt[p] >= thr);
        end

        // synchronous reset; straps are caught on every reset cycle
        if (rst_i) begin
            next_r           = '0;
            next_r.host_ctrl = HOST_CTRL_RST;
            next_r.host_ctrl[HALF_DUPLEX_BIT] = duplex_strap_pin_i;
            next_r.host_ctrl[FLOW_CTRL_BIT]   = pause_strap_pin_i;
            next_r.host_ctrl[SPEED_10_BIT]    = speed_strap_pin_i;
            next_r.host_ctrl[2:0] = STORM_THR_RST[10:8];
            next_r.storm_lo       = STORM_LO_RST;
            next_r.ctrl9          = CTRL9_RST;
        end
    end

    always_ff @(posedge mclk_i) begin
        r <= next_r;
    end

    // ==================================================================
    // outputs
    assign prdata_o           = r.rdata;
    assign pready_o           = r.ready;
    assign pslverr_o          = r.err;
    assign drop_bcast_o       = r.drop;
    assign vlan_id_o          = r.vid_out;
    assign host_half_duplex_o = r.host_ctrl[HALF_DUPLEX_BIT];
    assign host_flow_ctrl_o   = r.host_ctrl[FLOW_CTRL_BIT];
    assign host_speed_10_o    = r.host_ctrl[SPEED_10_BIT];
    assign null_vid_replace_o = r.host_ctrl[NULL_VID_BIT];
    assign back_pressure_o    = r.host_ctrl[BACK_PRESS_BIT];
    assign rmii_edge_o        = r.ctrl9[RMII_EDGE_BIT];
    assign power_save_o       = r.ctrl9[POWER_SAVE_BIT];
    assign storm_threshold_o  = thr;

    // ==================================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence host_write_s;
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_HOST_CTRL;
    endsequence

    sequence lo_write_s;
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_STORM_LO;
    endsequence

    apb_answer_a: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("apb answer not a single cycle after setup");

    duplex_write_a: assert property (
        host_write_s |=> host_half_duplex_o == $past(pwdata_i[HALF_DUPLEX_BIT]))
        else $error("duplex bit not taken from write");

    flow_write_a: assert property (
        host_write_s |=> host_flow_ctrl_o == $past(pwdata_i[FLOW_CTRL_BIT]))
        else $error("flow control bit not taken from write");

    speed_write_a: assert property (
        host_write_s |=> host_speed_10_o == $past(pwdata_i[SPEED_10_BIT]))
        else $error("speed bit not taken from write");

    duplex_strap_a: assert property (
        $fell(rst_i) |-> host_half_duplex_o == $past(duplex_strap_pin_i))
        else $error("duplex bit does not follow strap at release");

    pause_strap_a: assert property (
        $fell(rst_i) |-> host_flow_ctrl_o == $past(pause_strap_pin_i))
        else $error("flow control bit does not follow strap at release");

    speed_strap_a: assert property (
        $fell(rst_i) |-> host_speed_10_o == $past(speed_strap_pin_i))
        else $error("speed bit does not follow strap at release");

    vid_replace_a: assert property (
        null_vid_replace_o && vlan_id_i == '0 |=> vlan_id_o == $past(port_vid_i))
        else $error("null vlan identifier not replaced");

    thr_reset_a: assert property (
        $fell(rst_i) |-> storm_threshold_o == STORM_THR_RST)
        else $error("storm threshold reset value wrong");

    thr_layout_a: assert property (
        host_write_s |=> storm_threshold_o[10:8] == $past(pwdata_i[2:0]))
        else $error("upper threshold bits not placed at 10:8");

    thr_low_a: assert property (
        lo_write_s |=> storm_threshold_o[7:0] == $past(pwdata_i[7:0]))
        else $error("lower threshold byte not placed at 7:0");

    period_clear_a: assert property (
        (port_slow_i[0] ? tick_slow : tick_fast) |=> r.cnt[0] == '0)
        else $error("storm count not cleared at period start");

    drop_cause_a: assert property (
        drop_bcast_o[0] |-> r.cnt[0] >= $past(thr))
        else $error("broadcast drop without reaching threshold");

    count_step_a: assert property (
        !tick_fast && !tick_slow && !drop_bcast_o[0] && bcast_block_i[0]
        && r.cnt[0] < thr ##0 $stable(thr) |=> r.cnt[0] == $past(r.cnt[0]) + 1'b1)
        else $error("broadcast block not counted");

    // ==================================================================
    // bus and metering steps
    sequence port0_tick_s;
        port_slow_i[0] ? tick_slow : tick_fast;
    endsequence

    sequence last_block_s;
        bcast_block_i[0] && !(port_slow_i[0] ? tick_slow : tick_fast)
        && thr != '0 && r.cnt[0] == thr - 1'b1;
    endsequence

    bad_align_a: assert property (psel_i && !penable_i && paddr_i[1:0] != 2'b00
        |=> pslverr_o && prdata_o == '0)
        else $error("misaligned access not refused");

    idle_bus_a: assert property (!pready_o |-> !pslverr_o && prdata_o == '0)
        else $error("bus answer outside the answer cycle");

    test_read_a: assert property (
        psel_i && !penable_i && !pwrite_i && paddr_i == {IDX_TEST_B, 2'b00}
        |=> prdata_o == {24'h00_0000, TEST_B_VAL})
        else $error("fixed test register read wrong");

    ro_write_a: assert property (
        psel_i && penable_i && pready_o && pwrite_i && paddr_i[7:2] == IDX_TEST_A
        |=> $stable(storm_threshold_o))
        else $error("write to fixed test register changed a field");

    host_read_a: assert property (
        psel_i && !penable_i && !pwrite_i && paddr_i == ADDR_HOST_CTRL
        |=> prdata_o[6:4] == $past({host_half_duplex_o, host_flow_ctrl_o, host_speed_10_o}))
        else $error("host bits read back wrong");

    drop_rise_a: assert property (last_block_s |=> drop_bcast_o[0])
        else $error("drop not raised at threshold");

    drop_hold_a: assert property (
        drop_bcast_o[0] && !(port_slow_i[0] ? tick_slow : tick_fast) && $stable(thr)
        |=> drop_bcast_o[0])
        else $error("drop released inside a period");

    drop_clear_a: assert property (port0_tick_s ##0 thr != '0 |=> !drop_bcast_o[0])
        else $error("drop not released at period start");

    ctrl9_fixed_a: assert property ((r.ctrl9 & ~CTRL9_RW_MASK) == 8'h00)
        else $error("read-only control bits changed");

endmodule

// ---- hw/sgc_pkg.sv ----
// constants for the port-5 host interface and broadcast storm register bank
// assumes a 25 MHz core clock and word-aligned apb register access
package sgc_pkg;

    // ==================================================================
    // register indices and byte addresses (byte address = 4 * index)
    localparam logic [5:0] IDX_HOST_CTRL = 6'h06;
    localparam logic [5:0] IDX_STORM_LO  = 6'h07;
    localparam logic [5:0] IDX_TEST_A    = 6'h08;
    localparam logic [5:0] IDX_TEST_B    = 6'h09;
    localparam logic [5:0] IDX_TEST_C    = 6'h0a;
    localparam logic [5:0] IDX_CTRL9     = 6'h0b;
    localparam logic [7:0] ADDR_HOST_CTRL = {IDX_HOST_CTRL, 2'b00};
    localparam logic [7:0] ADDR_STORM_LO  = {IDX_STORM_LO, 2'b00};

    // ==================================================================
    // field positions
    localparam int BACK_PRESS_BIT  = 7;
    localparam int HALF_DUPLEX_BIT = 6;
    localparam int FLOW_CTRL_BIT   = 5;
    localparam int SPEED_10_BIT    = 4;
    localparam int NULL_VID_BIT    = 3;
    localparam int RMII_EDGE_BIT   = 6;
    localparam int POWER_SAVE_BIT  = 3;

    // ==================================================================
    // reset and fixed values
    localparam logic [7:0]  HOST_CTRL_RST = 8'h00;
    localparam logic [7:0]  STORM_LO_RST  = 8'h4a;
    localparam logic [7:0]  TEST_A_VAL    = 8'h00;
    localparam logic [7:0]  TEST_B_VAL    = 8'h4c;
    localparam logic [7:0]  TEST_C_VAL    = 8'h00;
    localparam logic [7:0]  CTRL9_RST     = 8'h00;
    localparam logic [7:0]  CTRL9_RW_MASK = 8'h48;
    localparam logic [10:0] STORM_THR_RST = 11'h04a;

    // ==================================================================
    // sizes
    localparam int NUM_PORTS = 5;
    localparam int THR_W     = 11;
    localparam int VID_W     = 12;
    localparam int TICK_W    = 24;

    // ==================================================================
    // storm period timing
    localparam int CLK_HZ         = 25_000_000;
    localparam int STORM_FAST_MS  = 50;
    localparam int STORM_SLOW_MS  = 500;
    localparam int STORM_FAST_CYC = STORM_FAST_MS * (CLK_HZ / 1000);
    localparam int STORM_SLOW_CYC = STORM_SLOW_MS * (CLK_HZ / 1000);

endpackage

// ---- hw/sgc_period_tick.sv ----
// repeating period timer: one-cycle tick at the end of every period
// assumes PERIOD_CYC fits in TICK_W bits and is at least 2
`timescale 1ns/1ps

module sgc_period_tick
    import sgc_pkg::*;
#(
    parameter int unsigned PERIOD_CYC = 1000
) (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    output logic      tick_o
);

    typedef struct packed {
        logic [TICK_W-1:0] count;
        logic              tick;
    } sgc_tick_state_t;

    localparam logic [TICK_W-1:0] LAST = TICK_W'(PERIOD_CYC - 1);

    sgc_tick_state_t r;
    sgc_tick_state_t next_r;

    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (r.count == LAST) begin
            next_r.count = '0;
            next_r.tick  = 1'b1;
        end else begin
            next_r.count = r.count + 1'b1;
        end
        if (rst_i) begin
            next_r = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        r <= next_r;
    end

    assign tick_o = r.tick;

    tick_single_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        tick_o |=> !tick_o) else $error("period tick lasted more than one cycle");

endmodule

// ---- bench/sgc_mac_model.sv ----
// far-side mac model: floods broadcast blocks on chosen ports
// assumes one block pulse per cycle is the fastest legal rate
`timescale 1ns/1ps

module sgc_mac_model
    import sgc_pkg::*;
(
    input  wire logic                         mclk_i,
    input  wire logic [sgc_pkg::NUM_PORTS-1:0] flood_en_i,
    output logic      [sgc_pkg::NUM_PORTS-1:0] bcast_block_o
);
    import sgc_pkg::*;
    // ==========================================
    // block pulses launched just after the edge
    always @(posedge mclk_i) begin
        bcast_block_o <= flood_en_i;
    end
endmodule

// ---- bench/switch_port5_global_control_tb.sv ----
// self-checking bench for the host port and storm register bank
// assumes shortened storm periods; apb answers are waited for, bounded
`timescale 1ns/1ps

module switch_port5_global_control_tb;
    import sgc_pkg::*;
    localparam int FAST = 20;
    localparam int SLOW = 50;

    logic                 mclk_i             = 1'b0;
    logic                 rst_i              = 1'b1;
    logic                 psel_i             = 1'b0;
    logic                 penable_i          = 1'b0;
    logic                 pwrite_i           = 1'b0;
    logic [7:0]           paddr_i            = 8'h00;
    logic [31:0]          pwdata_i           = 32'h0000_0000;
    logic                 duplex_strap_pin_i = 1'b0;
    logic                 pause_strap_pin_i  = 1'b0;
    logic                 speed_strap_pin_i  = 1'b0;
    logic [NUM_PORTS-1:0] port_slow_i        = 5'h02;
    logic [NUM_PORTS-1:0] flood              = 5'h00;
    logic [VID_W-1:0]     vlan_id_i          = 12'h000;
    logic [VID_W-1:0]     port_vid_i         = 12'h123;
    logic [31:0]          prdata_o;
    logic                 pready_o;
    logic                 pslverr_o;
    logic [NUM_PORTS-1:0] bcast_block_i;
    logic [NUM_PORTS-1:0] drop_bcast_o;
    logic [VID_W-1:0]     vlan_id_o;
    logic                 host_half_duplex_o;
    logic                 host_flow_ctrl_o;
    logic                 host_speed_10_o;
    logic                 null_vid_replace_o;
    logic                 back_pressure_o;
    logic                 power_save_o;
    logic                 rmii_edge_o;
    logic [THR_W-1:0]     storm_threshold_o;
    int                   errors             = 0;
    int                   checks             = 0;

    sgc_ctrl_regs #(.FAST_PERIOD_CYC(FAST), .SLOW_PERIOD_CYC(SLOW)) dut (
        .mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .duplex_strap_pin_i, .pause_strap_pin_i,
        .speed_strap_pin_i, .port_slow_i, .bcast_block_i, .drop_bcast_o,
        .vlan_id_i, .port_vid_i, .vlan_id_o, .host_half_duplex_o, .host_flow_ctrl_o,
        .host_speed_10_o, .null_vid_replace_o, .back_pressure_o, .rmii_edge_o,
        .power_save_o, .storm_threshold_o
    );

    sgc_mac_model mac (.mclk_i, .flood_en_i(flood), .bcast_block_o(bcast_block_i));

    always #20 mclk_i = ~mclk_i;

    // ==========================================
    // reporting
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================
    // apb master and helpers
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= {24'h00_0000, d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1 && n < 16) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 16) begin
            errors++;
            tally_and_finish();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(negedge mclk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic eerr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 8'h00, rd, err);
        check("prdata", rd, {24'h00_0000, exp});
        check("pslverr", {31'h0000_0000, err}, {31'h0000_0000, eerr});
    endtask

    task automatic do_reset(input logic [2:0] s);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        {duplex_strap_pin_i, pause_strap_pin_i, speed_strap_pin_i} <= s;
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
    endtask

    task automatic vid_chk(input logic [11:0] vin, input logic [11:0] exp);
        @(posedge mclk_i);
        vlan_id_i <= vin;
        repeat (2) @(negedge mclk_i);
        check("vlan_id", vlan_id_o, exp);
    endtask

    task automatic wait_lvl(input int p, input logic lvl, output int n);
        n = 0;
        while (drop_bcast_o[p] !== lvl && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= 200) begin
            errors++;
            tally_and_finish();
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_straps();
        do_reset(3'b101);
        check("half", host_half_duplex_o, 1'b1);
        check("pause", host_flow_ctrl_o, 1'b0);
        check("speed10", host_speed_10_o, 1'b1);
        check("threshold", storm_threshold_o, 11'h04a);
        rd_chk(8'h18, 8'h50, 1'b0);
        rd_chk(8'h1c, 8'h4a, 1'b0);
        do_reset(3'b010);
        rd_chk(8'h18, 8'h20, 1'b0);
        check("pause", host_flow_ctrl_o, 1'b1);
    endtask

    task automatic t_ro();
        logic [7:0] a [3] = '{8'h20, 8'h24, 8'h28};
        logic [7:0] v [3] = '{8'h00, 8'h4c, 8'h00};
        for (int i = 0; i < 3; i++) begin
            wr(a[i], 8'hff);
            rd_chk(a[i], v[i], 1'b0);
        end
        wr(8'h2c, 8'hff);
        rd_chk(8'h2c, 8'h48, 1'b0);
        check("rmii_edge", rmii_edge_o, 1'b1);
        check("power_save", power_save_o, 1'b1);
        rd_chk(8'h40, 8'h00, 1'b1);
        rd_chk(8'h19, 8'h00, 1'b1);
    endtask

    task automatic t_host();
        wr(8'h18, 8'hf8);
        check("half", host_half_duplex_o, 1'b1);
        check("pause", host_flow_ctrl_o, 1'b1);
        check("speed10", host_speed_10_o, 1'b1);
        check("null_vid", null_vid_replace_o, 1'b1);
        check("back_pressure", back_pressure_o, 1'b1);
        vid_chk(12'h000, 12'h123);
        vid_chk(12'h005, 12'h005);
        wr(8'h18, 8'h00);
        check("half", host_half_duplex_o, 1'b0);
        check("pause", host_flow_ctrl_o, 1'b0);
        check("speed10", host_speed_10_o, 1'b0);
        check("null_vid", null_vid_replace_o, 1'b0);
        check("back_pressure", back_pressure_o, 1'b0);
        vid_chk(12'h000, 12'h000);
    endtask

    task automatic t_thr();
        wr(8'h18, 8'h07);
        wr(8'h1c, 8'h3c);
        check("threshold", storm_threshold_o, 11'h73c);
        rd_chk(8'h18, 8'h07, 1'b0);
    endtask

    task automatic t_storm();
        int lo;
        int hi;
        int per [2] = '{FAST, SLOW};
        wr(8'h18, 8'h00);
        wr(8'h1c, 8'h03);
        @(posedge mclk_i);
        flood <= 5'h03;
        @(negedge mclk_i);
        for (int p = 0; p < 2; p++) begin
            wait_lvl(p, 1'b1, lo);
            wait_lvl(p, 1'b0, lo);
            wait_lvl(p, 1'b1, lo);
            wait_lvl(p, 1'b0, hi);
            check("low_cycles", 32'(lo), 32'h0000_0003);
            check("period", 32'(lo + hi), 32'(per[p]));
        end
        check("idle_ports", drop_bcast_o[4:2], 3'h0);
        @(posedge mclk_i);
        flood <= 5'h00;
    endtask

    initial begin
        t_straps();
        t_ro();
        t_host();
        t_thr();
        t_storm();
        tally_and_finish();
    end
endmodule
